// ---- logic/srwp_regs.vh ----
`ifndef SRWP_REGS_VH
`define SRWP_REGS_VH
`define SRWP_DEV_ADDR      7'h18
`define SRWP_ADDR_BITS     7
`define SRWP_BYTE_BITS     8
`define SRWP_PTR_RESET     8'h00
`define SRWP_PTR_POINTER_AUTOADVANCE_ENABLE_BIT  7
`define SRWP_PTR_ADDR_HI   4
`define SRWP_BLK1_LAST     5'h08
`define SRWP_BLK1_FIRST    5'h01
`define SRWP_BLK2_FIRST    5'h09
`define SRWP_BLK2_LAST     5'h11
`define SRWP_NUM_REGS      18
`define SRWP_REG_RESET     8'h00
`define SRWP_ST_ADDR       2'h0
`define SRWP_ST_PTR        2'h1
`define SRWP_ST_DATA       2'h2
`define SRWP_ST_IGNORE     2'h3
`endif

// ---- logic/srwp_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser; only the second stage is visible outside
module srwp_sync (
  input  wire core_clk, // system clock
  input  wire srst,     // synchronous reset
  input  wire d,        // asynchronous input
  output reg  q         // synchronised level
);
  reg meta;
  always @(posedge core_clk) begin
    if (srst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // srwp_sync
`default_nettype wire

// ---- logic/srwp_port.v ----
`timescale 1ns/1ps
`default_nettype none
`include "srwp_regs.vh"
// Overview of operation
// - first seven bits are device address
// - next byte loads register pointer
// - following byte written to pointed register
// - further bytes are further register writes
// - chip select high ends transaction
// - pointer bit 7 enables auto-advance, reset off
// - auto-advance within 01h-08h and 09h-11h
// - never advance from 08h to 09h
// - five-bit address field, reserved bits zero
// - no auto-advance keeps pointer fixed
// - data sampled on rising serial clock
// - write-only, all link signals inputs
module srwp_port (
  input  wire         core_clk,               // 50 MHz system clock
  input  wire         srst,                   // synchronous reset, active high
  input  wire         chip_select_n,          // serial chip select, active low
  input  wire         control_serial_clock,   // serial bit clock
  input  wire         control_serial_data_in, // serial data
  output reg  [7:0]   register_pointer,       // current pointer byte
  output reg  [143:0] config_regs,            // registers 00h..11h, 8 bits each
  output reg          write_strobe,           // one-cycle pulse per register write
  output reg  [4:0]   write_addr,             // address of last write
  output reg  [7:0]   write_data              // data of last write
);
  wire cs_n_s;
  wire sclk_s;
  wire sdi_s;
  reg  sclk_d;
  reg  cs_n_d;
  reg  [1:0] state;
  reg  [3:0] bit_cnt;
  reg  [7:0] shreg;
  reg  [7:0] next_byte;
  wire       sclk_rise;
  wire       cs_fall;
  wire       byte_done;

  srwp_sync u_sync_cs (.core_clk(core_clk), .srst(srst), .d(chip_select_n), .q(cs_n_s));
  srwp_sync u_sync_ck (.core_clk(core_clk), .srst(srst), .d(control_serial_clock), .q(sclk_s));
  srwp_sync u_sync_dt (.core_clk(core_clk), .srst(srst), .d(control_serial_data_in), .q(sdi_s));

  assign sclk_rise = sclk_s & ~sclk_d;
  assign cs_fall   = cs_n_d & ~cs_n_s;

  // next pointer address after a data byte, confined to its block
  function [4:0] advance;
    input [4:0] a;
    begin
      if (a == `SRWP_BLK1_LAST)
        advance = `SRWP_BLK1_FIRST;
      else if (a == `SRWP_BLK2_LAST)
        advance = `SRWP_BLK2_FIRST;
      else if (a == 5'h00)
        advance = a;
      else
        advance = a + 5'h01;
    end
  endfunction

  always @* begin
    next_byte = {shreg[6:0], sdi_s};
  end

  // every byte, address byte included, is the same length
  localparam [3:0] LAST_BIT = `SRWP_BYTE_BITS - 1;
  assign byte_done = sclk_rise && (bit_cnt == LAST_BIT);

  always @(posedge core_clk) begin
    if (srst) begin
      sclk_d           <= 1'b0;
      cs_n_d           <= 1'b1;
      state            <= `SRWP_ST_ADDR;
      bit_cnt          <= 4'h0;
      shreg            <= 8'h00;
      register_pointer <= `SRWP_PTR_RESET;
      config_regs      <= {`SRWP_NUM_REGS{`SRWP_REG_RESET}};
      write_strobe     <= 1'b0;
      write_addr       <= 5'h00;
      write_data       <= 8'h00;
    end else begin
      sclk_d       <= sclk_s;
      cs_n_d       <= cs_n_s;
      write_strobe <= 1'b0;
      if (cs_n_s || cs_fall) begin
        // deselect aborts any partial byte; restart on next select
        state   <= `SRWP_ST_ADDR;
        bit_cnt <= 4'h0;
        shreg   <= 8'h00;
      end else if (sclk_rise && state != `SRWP_ST_IGNORE) begin
        shreg   <= next_byte;
        bit_cnt <= byte_done ? 4'h0 : bit_cnt + 4'h1;
        if (byte_done) begin
          case (state)
            `SRWP_ST_ADDR: begin
              if (next_byte[7:1] == `SRWP_DEV_ADDR && !next_byte[0])
                state <= `SRWP_ST_PTR;
              else
                state <= `SRWP_ST_IGNORE;
            end
            `SRWP_ST_PTR: begin
              // reserved bits 6:5 forced to zero
              register_pointer <= {next_byte[`SRWP_PTR_POINTER_AUTOADVANCE_ENABLE_BIT], 2'b00,
                                   next_byte[`SRWP_PTR_ADDR_HI:0]};
              state <= `SRWP_ST_DATA;
            end
            `SRWP_ST_DATA: begin
              // unmapped addresses above 11h are not stored, but strobe, address and data still report the write
              if (register_pointer[4:0] <= `SRWP_BLK2_LAST)
                config_regs[register_pointer[4:0]*8 +: 8] <= next_byte;
              write_strobe <= 1'b1;
              write_addr   <= register_pointer[4:0];
              write_data   <= next_byte;
              if (register_pointer[`SRWP_PTR_POINTER_AUTOADVANCE_ENABLE_BIT])
                register_pointer[4:0] <= advance(register_pointer[4:0]);
            end
            default: state <= `SRWP_ST_IGNORE;
          endcase
        end
      end
    end
  end
endmodule // srwp_port
`default_nettype wire

// ---- dv/srwp_port_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module srwp_port_checker (
  input wire logic         core_clk,
  input wire logic         srst,
  input wire logic         chip_select_n,
  input wire logic [7:0]   register_pointer,
  input wire logic [143:0] config_regs,
  input wire logic         write_strobe,
  input wire logic [4:0]   write_addr,
  input wire logic [7:0]   write_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_quiet;
    !write_strobe [*8];
  endsequence
  chk_strobe_gap: assert property (write_strobe |=> s_quiet)
    else $error("strobe too close");
  chk_reg_load: assert property (write_strobe && write_addr < 5'h12 |->
    ##[0:1] config_regs[{write_addr, 3'h0} +: 8] == write_data) else $error("reg not loaded");
  chk_cfg_cause: assert property ($changed(config_regs) |-> write_strobe || $past(write_strobe))
    else $error("reg changed alone");
  chk_resv_zero: assert property (register_pointer[6:5] == 2'h0) else $error("reserved set");
  chk_no_cross: assert property (write_strobe && write_addr == 5'h08 && register_pointer[7] |->
    (register_pointer[4:0] != 5'h09) [*3]) else $error("crossed blocks");
  chk_hold_fixed: assert property (write_strobe && !register_pointer[7] |->
    $stable(register_pointer) [*4]) else $error("pointer moved");
  chk_idle_quiet: assert property (chip_select_n [*8] |-> !write_strobe) else $error("idle write");
  chk_addr_ptr: assert property (write_strobe && !register_pointer[7] |->
    write_addr == register_pointer[4:0]) else $error("wrong address");
endmodule // srwp_port_checker
bind srwp_port srwp_port_checker u_chk (.core_clk(core_clk), .srst(srst),
  .chip_select_n(chip_select_n), .register_pointer(register_pointer), .config_regs(config_regs),
  .write_strobe(write_strobe), .write_addr(write_addr), .write_data(write_data));
`default_nettype wire

// ---- dv/srwp_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module srwp_master (
  output var logic cs_n, // select, active low
  output var logic sclk, // bit clock
  output var logic sdi   // data
);
  initial {cs_n, sclk, sdi} = 3'h5;
  task automatic xfer(input logic [7:0] q[$]);
    cs_n = 1'b0;
    foreach (q[k]) for (int i = 7; i >= 0; i--) begin
      sdi = q[k][i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    sdi = ~sdi;
    #400;
  endtask
endmodule // srwp_master
`default_nettype wire

// ---- dv/tb_srwp_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_srwp_port;
  logic core_clk, srst, cs_n, sclk, sdi, stb;
  logic [7:0] ptr, wd, mp;
  logic [4:0] wa;
  logic [143:0] cfg, m;
  int error_cnt, compares, cyc;
  logic [31:0] s = 32'h4E;
  logic [12:0] expq[$];
  logic [12:0] e;
  srwp_master u_m (.cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  srwp_port u_dut (.core_clk(core_clk), .srst(srst), .chip_select_n(cs_n),
    .control_serial_clock(sclk), .control_serial_data_in(sdi), .register_pointer(ptr),
    .config_regs(cfg), .write_strobe(stb), .write_addr(wa), .write_data(wd));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [143:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] rnd;
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s[7:0];
  endfunction
  // reference: only a matching write frame touches pointer and registers
  task automatic wr(input logic [7:0] dv, pt, input int n);
    logic [7:0] q[$];
    logic [7:0] d;
    logic [4:0] a;
    q = {dv, pt};
    if (dv == 8'h30) mp = {pt[7], 2'h0, pt[4:0]};
    for (int i = 0; i < n; i++) begin
      d = rnd();
      q.push_back(d);
      a = mp[4:0];
      if (dv == 8'h30) expq.push_back({a, d});
      if (dv == 8'h30 && a < 5'h12) m[{a, 3'h0} +: 8] = d;
      if (dv == 8'h30 && mp[7]) mp[4:0] = (a == 5'h08) ? 5'h01 : (a == 5'h11) ? 5'h09 :
        (a == 5'h00) ? a : a + 5'h01;
    end
    @(negedge core_clk);
    u_m.xfer(q);
    chk("ptr", {136'h0, ptr}, {136'h0, mp});
    chk("cfg", cfg, m);
  endtask
  initial begin
    srst = 1'b1;
    m = '0;
    mp = 8'h00;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("ptr", {136'h0, ptr}, 144'h0);
    wr(8'h30, 8'h62, 3);
    wr(8'h30, 8'h86, 4);
    wr(8'h30, 8'h8F, 4);
    wr(8'h32, 8'h03, 2);
    wr(8'h31, 8'h04, 2);
    wr(8'h30, 8'h80, 2);
    chk("left", {112'h0, expq.size()}, 144'h0);
    test_done;
  end
  // every strobe is checked against the next expected write, off the launching edge
  always @(negedge core_clk) begin
    if (!srst && stb === 1'b1) begin
      e = (expq.size() != 0) ? expq.pop_front() : 13'h1FFF;
      chk("wr", {131'h0, wa, wd}, {131'h0, e});
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done;
    end
  end
endmodule // tb_srwp_port
`default_nettype wire
